// ### att_map.svh
`ifndef ATT_MAP_SVH
`define ATT_MAP_SVH

// Register byte offsets on the APB bus.
`define ATT_OFF_COUNT 8'h00
`define ATT_OFF_CMP_A 8'h04
`define ATT_OFF_CMP_B 8'h08
`define ATT_OFF_FLAG 8'h0c
`define ATT_OFF_MASK 8'h10
`define ATT_OFF_ASYNC 8'h14
`define ATT_OFF_CTRL 8'h18
`define ATT_OFF_POWER 8'h1c

// Flag and mask bit positions.
`define ATT_BIT_OVF 0
`define ATT_BIT_CMPA 1
`define ATT_BIT_CMPB 2

// Control register field positions.
`define ATT_CS_LSB 0
`define ATT_WGM_LSB 3
`define ATT_COMA_LSB 6
`define ATT_COMB_LSB 8

// Waveform generation modes.
`define ATT_WGM_NORMAL 3'h0
`define ATT_WGM_CTC 3'h2
`define ATT_WGM_FPWM 3'h3
`define ATT_WGM_FPWM_A 3'h7

// Reset values and extreme counter values.
`define ATT_RST_BYTE 8'h00
`define ATT_BOTTOM 8'h00
`define ATT_MAX 8'hff

// Prescaler tap masks, one per dividing clock select value (2 to 7).
`define ATT_DIV_8 10'h007
`define ATT_DIV_32 10'h01f
`define ATT_DIV_64 10'h03f
`define ATT_DIV_128 10'h07f
`define ATT_DIV_256 10'h0ff
`define ATT_DIV_1024 10'h3ff

`endif

// ### att_pkg.sv
package att_pkg;

	typedef enum logic {ATT_BUS_IDLE, ATT_BUS_ANSWER} att_bus_t;

	typedef struct packed {
		logic [7:0] count;
		logic [7:0] buf_a;
		logic [7:0] buf_b;
		logic [7:0] act_a;
		logic [7:0] act_b;
		logic [2:0] flags;
		logic [2:0] mask;
		logic async_sel;
		logic [2:0] clk_sel;
		logic [2:0] wgm;
		logic [1:0] com_a;
		logic [1:0] com_b;
		logic power_gate;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		att_bus_t bus;
	} att_state_t;

endpackage

// ### att_prescaler.sv
`timescale 1ns/1ps
`include "att_map.svh"

module att_prescaler (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Control.
	input wire logic enable,
	input wire logic async_sel,
	input wire logic [2:0] clk_sel,
	// Crystal oscillator input.
	input wire logic crystal_osc_pins,
	// Timer tick.
	output logic timer_tick
);

	logic osc_s1;
	logic osc_s2;
	logic osc_s3;
	logic [9:0] pre;
	logic base_en;
	logic [9:0] tap;

	// The crystal input is synchronised before its rising edge is used.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_s1 <= 1'b0;
			osc_s2 <= 1'b0;
			osc_s3 <= 1'b0;
			pre <= 10'h000;
		end else begin
			osc_s1 <= crystal_osc_pins;
			osc_s2 <= osc_s1;
			osc_s3 <= osc_s2;
			if (enable && base_en)
				pre <= pre + 10'h001;
		end
	end

	assign base_en = async_sel ? (osc_s2 & ~osc_s3) : 1'b1;

	always_comb begin
		case (clk_sel)
			3'h1: tap = 10'h000;
			3'h2: tap = `ATT_DIV_8;
			3'h3: tap = `ATT_DIV_32;
			3'h4: tap = `ATT_DIV_64;
			3'h5: tap = `ATT_DIV_128;
			3'h6: tap = `ATT_DIV_256;
			3'h7: tap = `ATT_DIV_1024;
			default: tap = 10'h000;
		endcase
	end

	// No tick at all while stopped or gated off.
	assign timer_tick = enable && (clk_sel != 3'h0) && base_en &&
		((pre & tap) == tap);

endmodule // att_prescaler

// ### att_wavegen.sv
`timescale 1ns/1ps

module att_wavegen (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Events from the counter.
	input wire logic tick,
	input wire logic match,
	input wire logic wrap,
	input wire logic pwm,
	input wire logic [1:0] com,
	// Compare output pin.
	output logic pin
);

	logic oc;
	logic next_oc;

	always_comb begin
		next_oc = oc;
		if (tick && pwm) begin
			// Fast PWM: the match wins over the wrap when both coincide.
			if (match && com == 2'h1)
				next_oc = ~oc;
			else if (match && com[1])
				next_oc = com[0];
			else if (wrap && com[1])
				next_oc = ~com[0];
		end else if (tick && match) begin
			case (com)
				2'h1: next_oc = ~oc;
				2'h2: next_oc = 1'b0;
				2'h3: next_oc = 1'b1;
				default: next_oc = oc;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oc <= 1'b0;
			pin <= 1'b0;
		end else begin
			oc <= next_oc;
			pin <= (com != 2'h0) ? next_oc : 1'b0;
		end
	end

endmodule // att_wavegen

// ### att_timer.sv
`timescale 1ns/1ps
`include "att_map.svh"

module att_timer (
	// APB clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Crystal oscillator input.
	input wire logic crystal_osc_pins,
	// Compare outputs and interrupt.
	output logic compare_out_a,
	output logic compare_out_b,
	output logic irq
);

	import att_pkg::*;

	att_state_t s;
	att_state_t next_s;
	logic timer_tick;
	logic pwm;
	logic [7:0] top;
	logic at_top;
	logic at_bottom;
	logic at_max;
	logic match_a;
	logic match_b;
	logic ovf_ev;
	logic setup;
	logic wr;
	logic wr_count;
	logic [2:0] set_flags;
	logic [2:0] clr_flags;
	logic [1:0] match_v;
	logic [1:0] com_v [2];
	logic [1:0] pin_v;
	logic [31:0] rd_val;
	logic rd_ok;

	att_prescaler u_pre (
		.pclk(pclk),
		.presetn(presetn),
		.enable(~s.power_gate),
		.async_sel(s.async_sel),
		.clk_sel(s.clk_sel),
		.crystal_osc_pins(crystal_osc_pins),
		.timer_tick(timer_tick)
	);

	// Counter state decode.
	assign pwm = (s.wgm == `ATT_WGM_FPWM) || (s.wgm == `ATT_WGM_FPWM_A);
	assign top = (s.wgm == `ATT_WGM_CTC || s.wgm == `ATT_WGM_FPWM_A) ?
		s.act_a : `ATT_MAX;
	assign at_top = (s.count == top);
	assign at_bottom = (s.count == `ATT_BOTTOM);
	assign at_max = (s.count == `ATT_MAX);
	assign match_a = (s.count == s.act_a);
	assign match_b = (s.count == s.act_b);
	// Overflow is counted when the counter leaves MAX, or TOP in PWM.
	assign ovf_ev = timer_tick && (pwm ? at_top : at_max);

	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite && s.pready;
	assign wr_count = wr && (paddr == `ATT_OFF_COUNT);

	always_comb begin
		set_flags = 3'h0;
		set_flags[`ATT_BIT_OVF] = ovf_ev;
		set_flags[`ATT_BIT_CMPA] = timer_tick && match_a;
		set_flags[`ATT_BIT_CMPB] = timer_tick && match_b;
		clr_flags = 3'h0;
		if (wr && paddr == `ATT_OFF_FLAG)
			clr_flags = pwdata[2:0];
	end

	// Read decode, done at setup so the answer comes from a flop.
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok = 1'b1;
		case (paddr)
			`ATT_OFF_COUNT: rd_val[7:0] = s.count;
			`ATT_OFF_CMP_A: rd_val[7:0] = s.buf_a;
			`ATT_OFF_CMP_B: rd_val[7:0] = s.buf_b;
			`ATT_OFF_FLAG: rd_val[2:0] = s.flags;
			`ATT_OFF_MASK: rd_val[2:0] = s.mask;
			`ATT_OFF_ASYNC: rd_val[0] = s.async_sel;
			`ATT_OFF_CTRL: rd_val[9:0] = {s.com_b, s.com_a, s.wgm, s.clk_sel};
			`ATT_OFF_POWER: rd_val[0] = s.power_gate;
			default: rd_ok = 1'b0;
		endcase
	end

	always_comb begin
		next_s = s;
		// Bus slave: one wait-free access phase per transfer.
		case (s.bus)
			ATT_BUS_IDLE: begin
				next_s.pready = 1'b0;
				next_s.pslverr = 1'b0;
				if (setup) begin
					next_s.bus = ATT_BUS_ANSWER;
					next_s.pready = 1'b1;
					next_s.pslverr = ~rd_ok;
					next_s.prdata = pwrite ? 32'h0000_0000 : rd_val;
				end
			end
			ATT_BUS_ANSWER: begin
				next_s.bus = ATT_BUS_IDLE;
				next_s.pready = 1'b0;
				next_s.pslverr = 1'b0;
			end
			default: next_s.bus = ATT_BUS_IDLE;
		endcase

		// A CPU write overrides any count or clear in the same cycle.
		if (wr_count)
			next_s.count = pwdata[7:0];
		else if (timer_tick)
			next_s.count = at_top ? `ATT_BOTTOM : s.count + 8'h01;

		// Non-PWM modes update the active compare value at once; PWM modes
		// wait for the wrap so a period never sees a torn duty cycle.
		if (!pwm || (timer_tick && at_top)) begin
			next_s.act_a = s.buf_a;
			next_s.act_b = s.buf_b;
		end

		// Set wins over a write-one-to-clear in the same cycle.
		next_s.flags = (s.flags & ~clr_flags) | set_flags;
		next_s.irq = |(next_s.flags & s.mask);

		if (wr) begin
			case (paddr)
				`ATT_OFF_CMP_A: next_s.buf_a = pwdata[7:0];
				`ATT_OFF_CMP_B: next_s.buf_b = pwdata[7:0];
				`ATT_OFF_MASK: next_s.mask = pwdata[2:0];
				`ATT_OFF_ASYNC: next_s.async_sel = pwdata[0];
				`ATT_OFF_CTRL: begin
					next_s.clk_sel = pwdata[`ATT_CS_LSB +: 3];
					next_s.wgm = pwdata[`ATT_WGM_LSB +: 3];
					next_s.com_a = pwdata[`ATT_COMA_LSB +: 2];
					next_s.com_b = pwdata[`ATT_COMB_LSB +: 2];
				end
				`ATT_OFF_POWER: next_s.power_gate = pwdata[0];
				default: next_s.bus = next_s.bus;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s.count <= `ATT_RST_BYTE;
			s.buf_a <= `ATT_RST_BYTE;
			s.buf_b <= `ATT_RST_BYTE;
			s.act_a <= `ATT_RST_BYTE;
			s.act_b <= `ATT_RST_BYTE;
			s.flags <= 3'h0;
			s.mask <= 3'h0;
			s.async_sel <= 1'b0;
			s.clk_sel <= 3'h0;
			s.wgm <= `ATT_WGM_NORMAL;
			s.com_a <= 2'h0;
			s.com_b <= 2'h0;
			s.power_gate <= 1'b0;
			s.prdata <= 32'h0000_0000;
			s.pready <= 1'b0;
			s.pslverr <= 1'b0;
			s.irq <= 1'b0;
			s.bus <= ATT_BUS_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign irq = s.irq;

	// One waveform channel per compare unit.
	assign match_v = {match_b, match_a};
	assign com_v[0] = s.com_a;
	assign com_v[1] = s.com_b;
	assign compare_out_a = pin_v[0];
	assign compare_out_b = pin_v[1];

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_wave
			att_wavegen u_wave (
				.pclk(pclk),
				.presetn(presetn),
				.tick(timer_tick),
				.match(match_v[ch]),
				.wrap(at_top),
				.pwm(pwm),
				.com(com_v[ch]),
				.pin(pin_v[ch])
			);
		end
	endgenerate

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// A tick on TOP that no CPU write overrides.
	sequence s_tick_at_top;
		timer_tick && at_top && !wr_count;
	endsequence

	// A plain count step, away from TOP and with no CPU write.
	sequence s_tick_step;
		timer_tick && !at_top && !wr_count;
	endsequence

	// A counter read offered in the setup phase.
	sequence s_count_read;
		setup && !pwrite && s.bus == ATT_BUS_IDLE &&
			paddr == `ATT_OFF_COUNT;
	endsequence

	// The crystal held still long enough to flush the edge detector, which
	// sits two flops behind the pin.
	sequence s_xtal_still;
		$stable(crystal_osc_pins) ##2 s.async_sel;
	endsequence

	a_flag_on_match: assert property (
		timer_tick && match_a |=> s.flags[`ATT_BIT_CMPA])
		else $error("compare A flag not set after match");
	a_ovf_flag: assert property (
		timer_tick && at_max && !pwm |=> s.flags[`ATT_BIT_OVF])
		else $error("overflow flag not set after leaving MAX");
	// The line follows the flags one cycle behind the mask.
	a_irq_gate: assert property (
		##1 (irq == |(s.flags & $past(s.mask))))
		else $error("interrupt output disagrees with flags and mask");
	a_flag_match_b: assert property (
		timer_tick && match_b |=> s.flags[`ATT_BIT_CMPB])
		else $error("compare B flag not set after match");
	// Only a write of one may drop a flag; a tick never does.
	a_flags_sticky: assert property (
		##1 (($past(s.flags) & ~$past(clr_flags) & ~s.flags) == 3'h0))
		else $error("flag dropped without a clear");
	a_irq_masked: assert property (
		s.mask == 3'h0 |=> !irq)
		else $error("interrupt raised with every source masked");
	a_stopped_hold: assert property (
		s.clk_sel == 3'h0 && !wr_count |=> $stable(s.count))
		else $error("counter moved with no clock selected");
	a_power_off: assert property (
		s.power_gate |-> !timer_tick)
		else $error("tick while the timer is powered off");
	a_top_wrap: assert property (
		s_tick_at_top |=> s.count == 8'h00)
		else $error("counter did not wrap to zero at TOP");
	a_buf_update: assert property (
		pwm && timer_tick && at_top |=> s.act_a == $past(s.buf_a))
		else $error("compare buffer not loaded at TOP");
	a_apb_answer: assert property (
		psel && !penable && s.bus == ATT_BUS_IDLE |=> pready ##1 !pready)
		else $error("bus answer not one cycle after setup");
	a_count_write: assert property (
		wr_count |=> s.count == $past(pwdata[7:0]))
		else $error("CPU write to counter lost");

	// Clock selection and counting. A stopped or gated timer must not even
	// produce a tick, or a compare flag could still be set by a match.
	a_stopped_tick: assert property (
		s.clk_sel == 3'h0 |-> !timer_tick)
		else $error("tick with no clock selected");
	a_sync_tick: assert property (
		!s.async_sel && !s.power_gate && s.clk_sel == 3'h1 |-> timer_tick)
		else $error("no tick from the undivided bus clock");
	a_xtal_quiet: assert property (
		s_xtal_still |-> !timer_tick)
		else $error("tick without a crystal edge");
	a_count_step: assert property (
		s_tick_step |=> s.count == $past(s.count) + 8'h01)
		else $error("counter did not advance on a tick");
	a_ctc_clear: assert property (
		s.wgm == `ATT_WGM_CTC && timer_tick && match_a && !wr_count |=>
		s.count == `ATT_BOTTOM)
		else $error("counter not cleared on compare A in CTC");
	a_bottom_after_ovf: assert property (
		ovf_ev && !wr_count |=> at_bottom)
		else $error("counter not at BOTTOM after overflow");
	a_max_wrap: assert property (
		timer_tick && at_max && !wr_count |=> at_bottom)
		else $error("counter did not wrap after MAX");
	a_buf_hold: assert property (
		pwm && !(timer_tick && at_top) |=> s.act_a == $past(s.act_a))
		else $error("active compare changed inside a PWM period");
	a_read_count: assert property (
		s_count_read |=> prdata == {24'h00_0000, $past(s.count)})
		else $error("counter read returned a wrong value");

	// Bus answer for an unmapped offset.
	a_bus_error: assert property (
		setup && s.bus == ATT_BUS_IDLE && !rd_ok |=>
		pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");

	// Waveform outputs. A pin whose mode bits are zero is held low.
	a_pin_a_off: assert property (
		s.com_a == 2'h0 |=> !compare_out_a)
		else $error("compare output A driven while disabled");
	a_pin_b_off: assert property (
		s.com_b == 2'h0 |=> !compare_out_b)
		else $error("compare output B driven while disabled");
	a_pwm_wrap_set: assert property (
		pwm && timer_tick && at_top && !match_b && s.com_b == 2'h2 |=>
		compare_out_b)
		else $error("PWM output B not set at the wrap");
	a_pwm_match_clr: assert property (
		pwm && timer_tick && match_b && s.com_b == 2'h2 |=> !compare_out_b)
		else $error("PWM output B not cleared on match");

endmodule // att_timer

// ### att_timer_test.sv
`timescale 1ns/1ps
`include "att_map.svh"

module att_timer_test;
	logic pclk, presetn, psel, penable, pwrite, crystal_osc_pins;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic pready, pslverr, compare_out_a, compare_out_b, irq, err, ok;
	logic xtal_run;
	int err_count, n_compared, xdiv, i, ha, hb;

	att_timer i_dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.crystal_osc_pins(crystal_osc_pins),
		.compare_out_a(compare_out_a),
		.compare_out_b(compare_out_b),
		.irq(irq)
	);

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// The crystal runs at one twentieth of pclk, toggled on its rising edge and so phase locked to it.
	always @(posedge pclk) begin
		if (xtal_run) begin
			if (xdiv == 9) begin
				xdiv <= 0;
				crystal_osc_pins <= ~crystal_osc_pins;
			end else begin
				xdiv <= xdiv + 1;
			end
		end
	end

	task conclude;
		$display("errors %0d, comparisons %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task cmp32(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task cmp1(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask

	// The request stands until a rising edge samples pready high; read data
	// and the error bit are taken at that same edge, then it is released.
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n == 20)
			err_count++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		cmp32(what, exp, q);
	endtask

	task run(input int n);
		repeat (n) @(posedge pclk);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		crystal_osc_pins = 1'b0;
		xtal_run = 1'b0;
		xdiv = 0;
		err_count = 0;
		n_compared = 0;
		run(12);
		presetn <= 1'b1;
		rdc(`ATT_OFF_COUNT, 32'h0, "count reset");
		rdc(`ATT_OFF_CMP_A, 32'h0, "compare a reset");
		rdc(`ATT_OFF_CMP_B, 32'h0, "compare b reset");
		rdc(`ATT_OFF_FLAG, 32'h0, "flags reset");
		rdc(`ATT_OFF_MASK, 32'h0, "mask reset");
		cmp1("irq reset", 1'b0, irq);
		wr(`ATT_OFF_CMP_A, 32'h1a5);
		rdc(`ATT_OFF_CMP_A, 32'ha5, "compare a width");
		wr(`ATT_OFF_CMP_B, 32'hfff3c);
		rdc(`ATT_OFF_CMP_B, 32'h3c, "compare b width");
		wr(`ATT_OFF_COUNT, 32'h210);
		run(40);
		rdc(`ATT_OFF_COUNT, 32'h10, "count stopped");
		apb(1'b0, 8'h40, 32'h0);
		cmp1("unmapped error", 1'b1, err);
		cmp32("unmapped data", 32'h0, q);
		wr(`ATT_OFF_POWER, 32'h1);
		wr(`ATT_OFF_CTRL, 32'h1);
		run(40);
		rdc(`ATT_OFF_COUNT, 32'h10, "count gated");
		wr(`ATT_OFF_CTRL, 32'h0);
		wr(`ATT_OFF_POWER, 32'h0);
		wr(`ATT_OFF_CMP_A, 32'h40);
		wr(`ATT_OFF_CMP_B, 32'h41);
		wr(`ATT_OFF_COUNT, 32'hfe);
		wr(`ATT_OFF_CTRL, 32'h1);
		run(10);
		wr(`ATT_OFF_CTRL, 32'h0);
		rdc(`ATT_OFF_FLAG, 32'h1, "overflow only");
		wr(`ATT_OFF_FLAG, 32'h1);
		rdc(`ATT_OFF_FLAG, 32'h0, "overflow cleared");
		wr(`ATT_OFF_COUNT, 32'h3e);
		wr(`ATT_OFF_CTRL, 32'h1);
		run(10);
		wr(`ATT_OFF_CTRL, 32'h0);
		rdc(`ATT_OFF_FLAG, 32'h6, "compare flags");
		wr(`ATT_OFF_MASK, 32'h1);
		run(3);
		cmp1("irq masked", 1'b0, irq);
		wr(`ATT_OFF_MASK, 32'h4);
		run(3);
		cmp1("irq unmasked", 1'b1, irq);
		wr(`ATT_OFF_FLAG, 32'h6);
		run(3);
		cmp1("irq cleared", 1'b0, irq);
		// CTC with top from compare a, pin a set on match, pin b left off.
		wr(`ATT_OFF_CMP_A, 32'h3);
		wr(`ATT_OFF_COUNT, 32'h0);
		wr(`ATT_OFF_CTRL, 32'hd1);
		for (i = 0; i < 6; i++) begin
			apb(1'b0, `ATT_OFF_COUNT, 32'h0);
			cmp1("count within top", 1'b1, q <= 32'h3);
		end
		cmp1("pin a set", 1'b1, compare_out_a);
		cmp1("pin b idle", 1'b0, compare_out_b);
		wr(`ATT_OFF_CTRL, 32'h0);
		rdc(`ATT_OFF_FLAG, 32'h2, "ctc flags");
		// Fast PWM, top from compare a = 9: pin a toggles on each match,
		// pin b is set at the wrap and cleared at 4, so high 5 of 10.
		wr(`ATT_OFF_CMP_A, 32'h9);
		wr(`ATT_OFF_CMP_B, 32'h4);
		wr(`ATT_OFF_COUNT, 32'h0);
		wr(`ATT_OFF_FLAG, 32'h7);
		wr(`ATT_OFF_CTRL, 32'h279);
		run(12);
		ha = 0;
		hb = 0;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (compare_out_a === 1'b1)
				ha++;
			if (compare_out_b === 1'b1)
				hb++;
		end
		cmp32("pwm a toggles", 32'ha, ha);
		cmp32("pwm b duty", 32'ha, hb);
		wr(`ATT_OFF_CTRL, 32'h0);
		rdc(`ATT_OFF_FLAG, 32'h7, "pwm flags");
		wr(`ATT_OFF_FLAG, 32'h7);
		wr(`ATT_OFF_COUNT, 32'h0);
		wr(`ATT_OFF_ASYNC, 32'h1);
		wr(`ATT_OFF_CTRL, 32'h1);
		run(60);
		rdc(`ATT_OFF_COUNT, 32'h0, "async still crystal");
		xtal_run <= 1'b1;
		run(100);
		xtal_run <= 1'b0;
		wr(`ATT_OFF_CTRL, 32'h0);
		apb(1'b0, `ATT_OFF_COUNT, 32'h0);
		ok = (q >= 32'h4) && (q <= 32'h6);
		cmp1("crystal edges counted", 1'b1, ok);
		rdc(`ATT_OFF_ASYNC, 32'h1, "async select");
		// A second reset in mid-run, with all but the control and power registers holding a value.
		presetn <= 1'b0;
		run(2);
		presetn <= 1'b1;
		rdc(`ATT_OFF_COUNT, 32'h0, "count reset again");
		rdc(`ATT_OFF_CMP_A, 32'h0, "compare a reset again");
		rdc(`ATT_OFF_CMP_B, 32'h0, "compare b reset again");
		rdc(`ATT_OFF_FLAG, 32'h0, "flags reset again");
		rdc(`ATT_OFF_MASK, 32'h0, "mask reset again");
		cmp1("irq reset again", 1'b0, irq);
		conclude;
	end

	// The tests need a few hundred cycles; this cuts a hang well beyond that.
	initial begin
		run(20000);
		err_count++;
		conclude;
	end
endmodule // att_timer_test
